/* File: dplc_ctrl.sv */
// Purpose: Power state, isolation link gating and off-hook calibration control
// Assumes: aresetn synchronous active low; bit clock and frame sync sampled on aclk
// Notes:   Sleep and deep powerdown are left only through aresetn
//
// Our own choice: the AXI4-Lite slave port.
`default_nettype none

// Functional notes
// - Reset defaults keep the line side powered down, never loading the line.
// - PLL locks within 1 ms from applying the bit clock.
// - Link is off after reset until the link powerdown bit clears.
// - Four power states chosen only by link powerdown and sleep bits.
// - Reset sets link powerdown, clears sleep; line status is invalid.
// - Both bits clear: normal operation with link traffic.
// - Link powerdown clear, sleep set: only link and ring detect work.
// - Only reset leaves sleep or powerdown; host then reprograms registers.
// - Both bits set: full powerdown, ring detect also dead.
// - Off-hook or loss of line power starts two automatic calibrations.
// - Resistor calibration lasts 17 ms, skipped when its disable bit is set.
// - 256 ms ADC calibration starts after dc settles and resistor cal ends.
// - Manual ADC cal: auto disable set, trigger pulsed; done within 256 ms. Here the 256 ms count only starts once dc settles.
module dplc_ctrl
(
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite write
    input  wire logic [9:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read
    input  wire logic [9:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Host timing inputs
    input  wire logic        bit_clk_active,
    input  wire logic        frame_sync,
    // Line side events
    input  wire logic        off_hook,
    input  wire logic        line_power_lost,
    input  wire logic        dc_term_stable,
    input  wire logic        ring_detect_in,
    input  wire logic        link_frame_ok,
    // Block outputs
    output logic             link_enable,
    output logic             ring_detect_out,
    output logic             pll_locked,
    output logic             cal_busy,
    output logic [1:0]       power_state
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    logic [7:0]            pwr_reg_q, pwr_reg_d;
    logic [7:0]            cal_reg_q, cal_reg_d;
    logic [7:0]            rcal_reg_q, rcal_reg_d;
    logic                  bvalid_q, bvalid_d;
    logic [1:0]            bresp_q, bresp_d;
    logic                  aw_held_q, aw_held_d;
    logic                  w_held_q, w_held_d;
    logic [9:0]            awaddr_q, awaddr_d;
    logic [31:0]           wdata_q, wdata_d;
    logic [3:0]            wstrb_q, wstrb_d;
    logic                  rvalid_q, rvalid_d;
    logic [31:0]           rdata_q, rdata_d;
    logic [1:0]            rresp_q, rresp_d;
    logic [15:0]           pll_cnt_q, pll_cnt_d;
    logic                  pll_lock_q, pll_lock_d;
    logic                  frame_sync_seen_q, frame_sync_seen_d;
    dplc_pkg::dplc_cal_t   cal_st_q, cal_st_d;
    logic [23:0]           cal_cnt_q, cal_cnt_d;
    logic                  hook_q, hook_d;
    logic                  manual_cal_trigger_q, manual_cal_trigger_d;
    logic                  ring_q, ring_d;
    dplc_pkg::dplc_pwr_t   pwr_mode;
    dplc_pkg::dplc_status_t status;
    logic                  wr_fire;
    logic [9:0]            wr_addr;
    logic [31:0]           wr_data;
    logic [3:0]            wr_strb;

    // Power state from the two control bits only
    function automatic dplc_pkg::dplc_pwr_t decode_pwr(input logic [7:0] r);
        unique case ({r[dplc_pkg::BIT_LINK_PD], r[dplc_pkg::BIT_SLEEP]})
            2'b10:   decode_pwr = dplc_pkg::PWR_RESET_OP;
            2'b00:   decode_pwr = dplc_pkg::PWR_NORMAL;
            2'b01:   decode_pwr = dplc_pkg::PWR_SLEEP;
            2'b11:   decode_pwr = dplc_pkg::PWR_DEEP_DOWN;
        endcase
    endfunction : decode_pwr

    // Byte lane 0 merge of a write
    function automatic logic [7:0] merge8(input logic [7:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
        merge8 = s[0] ? d[7:0] : old;
    endfunction : merge8

    assign pwr_mode = decode_pwr(pwr_reg_q);

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign status.link_en           = (pwr_mode == dplc_pkg::PWR_NORMAL)
                                    || (pwr_mode == dplc_pkg::PWR_SLEEP);
    assign status.ring_detect_en    = status.link_en;
    assign status.line_status_valid = status.link_en && link_frame_ok;
    assign status.cal_busy          = (cal_st_q != dplc_pkg::CAL_IDLE);
    assign link_enable     = status.link_en;
    assign ring_detect_out = ring_q;
    assign pll_locked      = pll_lock_q;
    assign cal_busy        = status.cal_busy;
    assign power_state     = pwr_mode;

    // ----------------------------------------------------------------
    // AXI4-Lite slave
    // ----------------------------------------------------------------
    assign s_axi_awready = !aw_held_q && !bvalid_q;
    assign s_axi_wready  = !w_held_q && !bvalid_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_arready = !rvalid_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;

    assign wr_addr = aw_held_q ? awaddr_q : s_axi_awaddr;
    assign wr_data = w_held_q ? wdata_q : s_axi_wdata;
    assign wr_strb = w_held_q ? wstrb_q : s_axi_wstrb;
    assign wr_fire = (aw_held_q || (s_axi_awvalid && s_axi_awready))
                   && (w_held_q || (s_axi_wvalid && s_axi_wready));

    // Write path, read path and register next values
    always_comb
    begin
        aw_held_d  = aw_held_q;
        w_held_d   = w_held_q;
        awaddr_d   = awaddr_q;
        wdata_d    = wdata_q;
        wstrb_d    = wstrb_q;
        bvalid_d   = bvalid_q && !s_axi_bready;
        bresp_d    = bresp_q;
        pwr_reg_d  = pwr_reg_q;
        cal_reg_d  = cal_reg_q;
        rcal_reg_d = rcal_reg_q;
        rvalid_d   = rvalid_q && !s_axi_rready;
        rdata_d    = rdata_q;
        rresp_d    = rresp_q;
        if (s_axi_awvalid && s_axi_awready)
        begin
            aw_held_d = 1'b1;
            awaddr_d  = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            w_held_d = 1'b1;
            wdata_d  = s_axi_wdata;
            wstrb_d  = s_axi_wstrb;
        end
        if (wr_fire)
        begin
            aw_held_d = 1'b0;
            w_held_d  = 1'b0;
            bvalid_d  = 1'b1;
            bresp_d   = dplc_pkg::RESP_OKAY;
            unique case (wr_addr)
                dplc_pkg::ADDR_POWER_STATE:
                begin
                    // Sleep and deep powerdown lock the bits until reset
                    if (pwr_mode == dplc_pkg::PWR_NORMAL
                        || pwr_mode == dplc_pkg::PWR_RESET_OP)
                        pwr_reg_d = merge8(pwr_reg_q, wr_data, wr_strb);
                end
                dplc_pkg::ADDR_CAL_CONTROL:  cal_reg_d  = merge8(cal_reg_q, wr_data, wr_strb);
                dplc_pkg::ADDR_RCAL_CONTROL: rcal_reg_d = merge8(rcal_reg_q, wr_data, wr_strb);
                dplc_pkg::ADDR_STATUS:       bresp_d    = dplc_pkg::RESP_OKAY;
                default:                     bresp_d    = dplc_pkg::RESP_SLVERR;
            endcase
        end
        if (s_axi_arvalid && s_axi_arready)
        begin
            rvalid_d = 1'b1;
            rresp_d  = dplc_pkg::RESP_OKAY;
            unique case (s_axi_araddr)
                dplc_pkg::ADDR_POWER_STATE:  rdata_d = {24'h000000, pwr_reg_q};
                dplc_pkg::ADDR_CAL_CONTROL:  rdata_d = {24'h000000, cal_reg_q};
                dplc_pkg::ADDR_RCAL_CONTROL: rdata_d = {24'h000000, rcal_reg_q};
                dplc_pkg::ADDR_STATUS:       rdata_d = {25'h0000000, pll_lock_q,
                                                        pwr_mode, status};
                default:
                begin
                    rdata_d = 32'h00000000;
                    rresp_d = dplc_pkg::RESP_SLVERR;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // PLL lock, ring detect and calibration sequencer
    // ----------------------------------------------------------------
    always_comb
    begin
        pll_cnt_d  = pll_cnt_q;
        pll_lock_d = pll_lock_q;
        // Lock counts from the bit clock, restarts if it stops
        if (!bit_clk_active)
        begin
            pll_cnt_d  = 16'h0000;
            pll_lock_d = 1'b0;
        end
        else if (pll_cnt_q == 16'(dplc_pkg::PLL_LOCK_CYC))
            pll_lock_d = pll_lock_q || frame_sync_seen_q || frame_sync;
        else
            pll_cnt_d = pll_cnt_q + 16'h0001;
        // Frame sync seen at any time while the bit clock runs
        frame_sync_seen_d = bit_clk_active && (frame_sync_seen_q || frame_sync);
        ring_d   = status.ring_detect_en && ring_detect_in;
        hook_d   = off_hook;
        manual_cal_trigger_d   = cal_reg_q[dplc_pkg::BIT_MAN_CAL];
        cal_st_d = cal_st_q;
        cal_cnt_d = cal_cnt_q;
        unique case (cal_st_q)
            dplc_pkg::CAL_IDLE:
            begin
                cal_cnt_d = 24'h000000;
                // Auto start on off-hook edge or power loss
                if (!cal_reg_q[dplc_pkg::BIT_AUTO_CAL_DIS]
                    && ((off_hook && !hook_q) || line_power_lost))
                    cal_st_d = rcal_reg_q[dplc_pkg::BIT_RCAL_DIS]
                             ? dplc_pkg::CAL_ADC : dplc_pkg::CAL_RES;
                // Manual start on the falling edge of the trigger
                else if (cal_reg_q[dplc_pkg::BIT_AUTO_CAL_DIS] && manual_cal_trigger_q
                         && !cal_reg_q[dplc_pkg::BIT_MAN_CAL])
                    cal_st_d = dplc_pkg::CAL_ADC;
            end
            dplc_pkg::CAL_RES:
            begin
                if (cal_cnt_q == 24'(dplc_pkg::RCAL_CYC - 1))
                begin
                    cal_cnt_d = 24'h000000;
                    cal_st_d  = dplc_pkg::CAL_ADC;
                end
                else
                    cal_cnt_d = cal_cnt_q + 24'h000001;
            end
            dplc_pkg::CAL_ADC:
            begin
                // Wait for dc termination before counting
                if (!dc_term_stable)
                    cal_cnt_d = 24'h000000;
                else if (cal_cnt_q == 24'(dplc_pkg::ADC_CAL_CYC - 1))
                    cal_st_d = dplc_pkg::CAL_IDLE;
                else
                    cal_cnt_d = cal_cnt_q + 24'h000001;
            end
            default: cal_st_d = dplc_pkg::CAL_IDLE;
        endcase
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pwr_reg_q  <= dplc_pkg::RST_POWER_STATE;
            cal_reg_q  <= dplc_pkg::RST_CAL_CONTROL;
            rcal_reg_q <= dplc_pkg::RST_RCAL_CONTROL;
            aw_held_q  <= 1'b0;
            w_held_q   <= 1'b0;
            awaddr_q   <= 10'h000;
            wdata_q    <= 32'h00000000;
            wstrb_q    <= 4'h0;
            bvalid_q   <= 1'b0;
            bresp_q    <= dplc_pkg::RESP_OKAY;
            rvalid_q   <= 1'b0;
            rdata_q    <= 32'h00000000;
            rresp_q    <= dplc_pkg::RESP_OKAY;
            pll_cnt_q  <= 16'h0000;
            pll_lock_q <= 1'b0;
            frame_sync_seen_q <= 1'b0;
            cal_st_q   <= dplc_pkg::CAL_IDLE;
            cal_cnt_q  <= 24'h000000;
            hook_q     <= 1'b0;
            manual_cal_trigger_q     <= 1'b0;
            ring_q     <= 1'b0;
        end
        else
        begin
            pwr_reg_q  <= pwr_reg_d;
            cal_reg_q  <= cal_reg_d;
            rcal_reg_q <= rcal_reg_d;
            aw_held_q  <= aw_held_d;
            w_held_q   <= w_held_d;
            awaddr_q   <= awaddr_d;
            wdata_q    <= wdata_d;
            wstrb_q    <= wstrb_d;
            bvalid_q   <= bvalid_d;
            bresp_q    <= bresp_d;
            rvalid_q   <= rvalid_d;
            rdata_q    <= rdata_d;
            rresp_q    <= rresp_d;
            pll_cnt_q  <= pll_cnt_d;
            pll_lock_q <= pll_lock_d;
            frame_sync_seen_q <= frame_sync_seen_d;
            cal_st_q   <= cal_st_d;
            cal_cnt_q  <= cal_cnt_d;
            hook_q     <= hook_d;
            manual_cal_trigger_q     <= manual_cal_trigger_d;
            ring_q     <= ring_d;
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    property p_reset_defaults;
        @(posedge aclk) !aresetn |=> (pwr_reg_q == 8'h10 && !link_enable);
    endproperty
    a_reset_defaults: assert property (p_reset_defaults)
        else $error("reset defaults wrong");

    property p_link_gated;
        @(posedge aclk) disable iff (!aresetn)
            pwr_reg_q[4] |-> !link_enable;
    endproperty
    a_link_gated: assert property (p_link_gated)
        else $error("link active while powered down");

    property p_normal_link;
        @(posedge aclk) disable iff (!aresetn)
            (pwr_reg_q[4:3] == 2'b00) |-> link_enable && power_state == 2'b01;
    endproperty
    a_normal_link: assert property (p_normal_link)
        else $error("normal mode link not enabled");

    property p_deep_no_ring;
        @(posedge aclk) disable iff (!aresetn)
            (pwr_reg_q[4:3] == 2'b11) |=> !ring_detect_out;
    endproperty
    a_deep_no_ring: assert property (p_deep_no_ring)
        else $error("ring detect alive in powerdown");

    property p_sleep_sticky;
        @(posedge aclk) disable iff (!aresetn)
            (power_state == 2'b10) |=> (power_state == 2'b10);
    endproperty
    a_sleep_sticky: assert property (p_sleep_sticky)
        else $error("left sleep without reset");

    property p_sleep_ring;
        @(posedge aclk) disable iff (!aresetn)
            (power_state == 2'b10 && ring_detect_in) |=> ring_detect_out;
    endproperty
    a_sleep_ring: assert property (p_sleep_ring)
        else $error("ring detect lost in sleep");

    property p_pll_lock;
        @(posedge aclk) disable iff (!aresetn)
            $rose(bit_clk_active) |-> !pll_locked [*8];
    endproperty
    a_pll_lock: assert property (p_pll_lock)
        else $error("pll lock too early");

    property p_auto_start;
        @(posedge aclk) disable iff (!aresetn)
            (cal_st_q == dplc_pkg::CAL_IDLE && !cal_reg_q[4] && line_power_lost)
                |=> cal_busy;
    endproperty
    a_auto_start: assert property (p_auto_start)
        else $error("auto calibration did not start");

    property p_rcal_skip;
        @(posedge aclk) disable iff (!aresetn)
            (cal_st_q == dplc_pkg::CAL_IDLE && cal_st_d != dplc_pkg::CAL_IDLE
             && rcal_reg_q[5]) |=> (cal_st_q == dplc_pkg::CAL_ADC);
    endproperty
    a_rcal_skip: assert property (p_rcal_skip)
        else $error("resistor calibration not skipped");

    property p_adc_waits;
        @(posedge aclk) disable iff (!aresetn)
            (cal_st_q == dplc_pkg::CAL_ADC && !dc_term_stable) |=> cal_cnt_q == 24'h0;
    endproperty
    a_adc_waits: assert property (p_adc_waits)
        else $error("adc calibration ran before dc settled");

endmodule : dplc_ctrl

`default_nettype wire

/* File: dplc_pkg.sv */
// Purpose: Shared constants and types for the power, link and calibration control
// Assumes: 50 MHz aclk, AXI4-Lite register access, 32-bit data
// Notes:   Printed register numbers are indexes; byte address is four times the index
`default_nettype none

package dplc_pkg;

    // ----------------------------------------------------------------
    // Register indexes and byte addresses
    // ----------------------------------------------------------------
    localparam logic [7:0]  IDX_POWER_STATE   = 8'h06;
    localparam logic [7:0]  IDX_CAL_CONTROL   = 8'h11;
    localparam logic [7:0]  IDX_RCAL_CONTROL  = 8'h19;
    localparam logic [7:0]  IDX_STATUS        = 8'h40;
    localparam logic [9:0]  ADDR_POWER_STATE  = {IDX_POWER_STATE, 2'b00};
    localparam logic [9:0]  ADDR_CAL_CONTROL  = {IDX_CAL_CONTROL, 2'b00};
    localparam logic [9:0]  ADDR_RCAL_CONTROL = {IDX_RCAL_CONTROL, 2'b00};
    localparam logic [9:0]  ADDR_STATUS       = {IDX_STATUS, 2'b00};

    // ----------------------------------------------------------------
    // Field positions and reset values
    // ----------------------------------------------------------------
    localparam int          BIT_LINK_PD       = 4;
    localparam int          BIT_SLEEP         = 3;
    localparam int          BIT_RCAL_DIS      = 5;
    localparam int          BIT_AUTO_CAL_DIS  = 4;
    localparam int          BIT_MAN_CAL       = 5;
    localparam logic [7:0]  RST_POWER_STATE   = 8'h10;
    localparam logic [7:0]  RST_CAL_CONTROL   = 8'h00;
    localparam logic [7:0]  RST_RCAL_CONTROL  = 8'h00;
    localparam logic [1:0]  RESP_OKAY         = 2'b00;
    localparam logic [1:0]  RESP_SLVERR       = 2'b10;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int          CLK_HZ            = 50_000_000;
    localparam int          PLL_LOCK_US       = 1000;
    localparam int          RCAL_MS           = 17;
    localparam int          ADC_CAL_MS        = 256;
    // Lock decided two cycles short of the limit, so it lands under 1 ms
    localparam int          PLL_LOCK_CYC      = (CLK_HZ / 1_000_000) * PLL_LOCK_US - 2;
    localparam int          RCAL_CYC          = (CLK_HZ / 1000) * RCAL_MS;
    localparam int          ADC_CAL_CYC       = (CLK_HZ / 1000) * ADC_CAL_MS;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [1:0]
    {
        PWR_RESET_OP  = 2'b00,
        PWR_NORMAL    = 2'b01,
        PWR_SLEEP     = 2'b10,
        PWR_DEEP_DOWN = 2'b11
    } dplc_pwr_t;

    typedef enum logic [1:0]
    {
        CAL_IDLE = 2'b00,
        CAL_RES  = 2'b01,
        CAL_ADC  = 2'b10
    } dplc_cal_t;

    typedef struct packed
    {
        logic       link_en;
        logic       ring_detect_en;
        logic       line_status_valid;
        logic       cal_busy;
    } dplc_status_t;

endpackage : dplc_pkg

`default_nettype wire

/* File: dplc_line_model.sv */
// Purpose: Far-side model: host frame timing and line-side frame status
// Assumes: One aclk domain, frame sync as a short periodic pulse
// Notes:   Frame status answers only while the isolation link runs
`default_nettype none

module dplc_line_model
(
    // Clock
    input  wire logic aclk,
    // Link gate from the block
    input  wire logic link_enable,
    // Far-side answers
    output logic      link_frame_ok,
    output logic      frame_sync
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [3:0] cnt_q = 4'h0;

    // ------------------------------------------------------------
    // Frame counter, sync pulse every 16 cycles
    // ------------------------------------------------------------
    always @(posedge aclk)
    begin
        cnt_q <= cnt_q + 4'h1;
    end

    // Dead link shows a toggling pattern, never a held value
    assign frame_sync    = (cnt_q == 4'hf);
    assign link_frame_ok = link_enable ? 1'b1 : cnt_q[0];
endmodule : dplc_line_model

`default_nettype wire

/* File: daa_power_link_calibration_control_bench.sv */
// Purpose: Self-checking bench for power state, link gate and calibration start
// Assumes: 50 MHz aclk, synchronous active-low reset, AXI4-Lite master tasks
// Notes:   Full calibration lengths exceed the run limit; only starts are checked
`default_nettype none

module daa_power_link_calibration_control_bench;
    timeunit 1ns;
    timeprecision 1ps;

    logic        aclk = 1'b0, aresetn = 1'b0;
    logic [9:0]  s_axi_awaddr = 10'h000, s_axi_araddr = 10'h000;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
    logic [3:0]  s_axi_wstrb = 4'h1;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, power_state, rsp;
    logic        bit_clk_active = 1'b0, off_hook = 1'b0, line_power_lost = 1'b0;
    logic        dc_term_stable = 1'b1, ring_detect_in = 1'b0;
    logic        frame_sync, link_frame_ok, link_enable, ring_detect_out, pll_locked, cal_busy;
    int          err_total = 0, cmp_count = 0, cyc = 0, n = 0, seed = 32'h4665f702;
    logic [7:0]  mdl_pwr = 8'h10;

    dplc_ctrl DUT (.*);
    dplc_line_model u_line (.*);

    // Clock and run ceiling
    always #10 aclk = ~aclk;
    always @(posedge aclk)
    begin
        cyc++;
        if (cyc == 60000)
        begin
            err_total++;
            tally_and_finish();
        end
    end

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            err_total++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic tally_and_finish();
        if (err_total == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : tally_and_finish

    // Bus write: both channels offered together, bready held for bvalid
    task automatic axi_wr(input logic [9:0] a, input logic [31:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_awready === 1'b1)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1)
                s_axi_wvalid <= 1'b0;
        end
        while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        check("bresp", 32'(s_axi_bresp), 32'(dplc_pkg::RESP_OKAY));
        if (a == dplc_pkg::ADDR_POWER_STATE && !mdl_pwr[3])
            mdl_pwr = d[7:0];
        @(posedge aclk);
    endtask : axi_wr

    task automatic axi_rd(input logic [9:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_arready === 1'b1)
                s_axi_arvalid <= 1'b0;
        end
        while (s_axi_rvalid !== 1'b1);
        rd = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask : axi_rd

    // Expected state from the two control bits
    function automatic logic [1:0] exp_st();
        return mdl_pwr[3] ? {1'b1, mdl_pwr[4]} : {1'b0, ~mdl_pwr[4]};
    endfunction : exp_st

    task automatic check_pwr();
        check("power_state", 32'(power_state), 32'(exp_st()));
        check("link_enable", 32'(link_enable), 32'(exp_st() inside {2'b01, 2'b10}));
        axi_rd(dplc_pkg::ADDR_POWER_STATE);
        check("power_reg", rd, 32'(mdl_pwr));
    endtask : check_pwr

    // Random ring level, seen one cycle later only where ring detect lives
    task automatic ring_chk();
        logic [31:0] b;
        b = $random(seed);
        ring_detect_in <= b[0];
        repeat (2) @(posedge aclk);
        check("ring_out", 32'(ring_detect_out),
              32'(b[0] && (exp_st() inside {2'b01, 2'b10})));
    endtask : ring_chk

    initial
    begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        check_pwr();
        axi_rd(dplc_pkg::ADDR_STATUS);
        check("status_reset", rd, 32'h0);
        axi_rd(10'h3fc);
        check("unmapped_resp", 32'(rsp), 32'(dplc_pkg::RESP_SLVERR));
        // Lock must follow the bit clock within 1 ms; clock kept running
        bit_clk_active <= 1'b1;
        n = 0;
        while (pll_locked !== 1'b1 && n < 50100)
        begin
            @(posedge aclk);
            n++;
        end
        check("pll_lock_in_time", 32'(n <= 50000), 32'h1);
        axi_wr(dplc_pkg::ADDR_POWER_STATE, 32'h0);
        check_pwr();
        repeat (6) ring_chk();
        // Off-hook starts the resistor calibration
        off_hook <= 1'b1;
        repeat (3) @(posedge aclk);
        check("cal_start", 32'(cal_busy), 32'h1);
        repeat (1000) @(posedge aclk);
        check("cal_held", 32'(cal_busy), 32'h1);
        axi_rd(dplc_pkg::ADDR_STATUS);
        check("status_run", rd, 32'h5f);
        axi_wr(dplc_pkg::ADDR_POWER_STATE, 32'h08);
        check_pwr();
        axi_wr(dplc_pkg::ADDR_POWER_STATE, 32'h0);
        check_pwr();
        ring_chk();
        // Line back on-hook while reset is pulsed
        off_hook <= 1'b0;
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        mdl_pwr = 8'h10;
        @(posedge aclk);
        check_pwr();
        axi_wr(dplc_pkg::ADDR_POWER_STATE, 32'h18);
        check_pwr();
        repeat (3) ring_chk();
        // Power loss starts calibration with the resistor step skipped
        axi_wr(dplc_pkg::ADDR_RCAL_CONTROL, 32'h20);
        line_power_lost <= 1'b1;
        @(posedge aclk);
        line_power_lost <= 1'b0;
        @(posedge aclk);
        check("cal_loss", 32'(cal_busy), 32'h1);
        // Reset, then manual calibration with dc not yet settled
        aresetn <= 1'b0;
        dc_term_stable <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        axi_wr(dplc_pkg::ADDR_CAL_CONTROL, 32'h10);
        axi_wr(dplc_pkg::ADDR_CAL_CONTROL, 32'h30);
        check("cal_idle", 32'(cal_busy), 32'h0);
        axi_wr(dplc_pkg::ADDR_CAL_CONTROL, 32'h10);
        @(posedge aclk);
        check("cal_manual", 32'(cal_busy), 32'h1);
        tally_and_finish();
    end
endmodule : daa_power_link_calibration_control_bench

`default_nettype wire
